// ### verilog/xps_map.vh
//
// Contract
// - Two banks, staging and active, each one 4-bit register per output.
// - Three low bits of each register name the input routed there.
// - Fourth bit chooses whether the output drives or floats.
// - The output address bus picks the staging register to write.
// - Staging strobe rising edge writes staging, only with device select high.
// - Apply strobe rising edge copies all staging registers to active at once.
// - Staging writes leave active routing and outputs untouched until apply.
// - Each output independently follows any input; inputs may fan out freely.
// - Init pulse rising edge with device select high routes outputs to input 0.
// - Init enables all outputs if float select low, floats them if high.
// - Lane count and address width are generics, defaults 8 and 3.
//
`ifndef XPS_MAP_VH
`define XPS_MAP_VH

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define XPS_LANES        8
`define XPS_ADDR_W       3
`define XPS_SYNC_STAGES  2

// ---------------------------------------------------------------
// APB register offsets
// ---------------------------------------------------------------
`define XPS_OFS_CTRL     8'h00
`define XPS_OFS_STAGE    8'h04
`define XPS_OFS_ACTIVE   8'h08
`define XPS_OFS_PINS     8'h0C

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define XPS_CTRL_APPLY   0
`define XPS_CTRL_INIT    1
`define XPS_CTRL_FLOAT   2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define XPS_RST_WORD     32'h0000_0000

`endif

// ### verilog/xps_sync.v
`timescale 1ns/1ps
module xps_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // ---------------------------------------------------------------
  // Two-flop synchroniser, first stage read only by the second
  // ---------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### verilog/xps_lane.v
`timescale 1ns/1ps
module xps_lane #(
  parameter N = 8,
  parameter M = 3
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [N-1:0] lane_in,
  input  wire [M-1:0] sel,
  input  wire         en,
  output reg          dout,
  output reg          oe
);

  // ---------------------------------------------------------------
  // One N:1 multiplexer with registered output and enable
  // ---------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
      oe   <= 1'b0;
    end else begin
      dout <= lane_in[sel];
      oe   <= en;
    end
  end

endmodule

// ### verilog/xps_top.v
`timescale 1ns/1ps
`include "xps_map.vh"
module xps_top #(
  parameter N = `XPS_LANES,
  parameter M = `XPS_ADDR_W
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  // Configuration pins
  input  wire         dev_sel,
  input  wire         stage_strobe,
  input  wire         apply_strobe,
  input  wire         init_pulse,
  input  wire         float_sel,
  input  wire [M-1:0] out_addr,
  input  wire [M-1:0] in_sel,
  input  wire         in_en,
  // Switch data path
  input  wire [N-1:0] switch_inputs,
  output wire [N-1:0] switch_outputs,
  output wire [N-1:0] switch_oe,
  // APB slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr
);

  localparam FW = M + 1;
  localparam BW = N * FW;
  localparam CW = 5 + 2 * M + 1;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  wire [CW-1:0] ctl_raw;
  wire [CW-1:0] ctl_q;
  wire [N-1:0]  data_q;

  assign ctl_raw = {in_en, in_sel, out_addr, float_sel,
                    init_pulse, apply_strobe, stage_strobe, dev_sel};

  xps_sync #(
    .W (CW)
  ) u_ctl_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (ctl_raw),
    .q       (ctl_q)
  );

  xps_sync #(
    .W (N)
  ) u_data_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (switch_inputs),
    .q       (data_q)
  );

  wire         s_dev_sel;
  wire         s_stage;
  wire         s_apply;
  wire         s_init;
  wire         s_float;
  wire [M-1:0] s_addr;
  wire [M-1:0] s_sel;
  wire         s_en;

  assign s_dev_sel = ctl_q[0];
  assign s_stage   = ctl_q[1];
  assign s_apply   = ctl_q[2];
  assign s_init    = ctl_q[3];
  assign s_float   = ctl_q[4];
  assign s_addr    = ctl_q[5 +: M];
  assign s_sel     = ctl_q[5 + M +: M];
  assign s_en      = ctl_q[5 + 2 * M];

  // ---------------------------------------------------------------
  // Strobe edge detection
  // ---------------------------------------------------------------
  reg stage_d;
  reg apply_d;
  reg init_d;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_d <= 1'b0;
      apply_d <= 1'b0;
      init_d  <= 1'b0;
    end else begin
      stage_d <= s_stage;
      apply_d <= s_apply;
      init_d  <= s_init;
    end
  end

  wire stage_rise;
  wire apply_rise;
  wire init_rise;

  assign stage_rise = s_stage & ~stage_d & s_dev_sel;
  assign apply_rise = s_apply & ~apply_d;
  assign init_rise  = s_init & ~init_d & s_dev_sel;

  // ---------------------------------------------------------------
  // APB access decode
  // ---------------------------------------------------------------
  wire apb_done;
  wire apb_wr;
  wire hit_ctrl;
  wire hit_stage;
  wire hit_active;
  wire hit_pins;
  wire hit_any;

  assign apb_done   = psel & penable & pready;
  assign apb_wr     = apb_done & pwrite;
  assign hit_ctrl   = (paddr == `XPS_OFS_CTRL);
  assign hit_stage  = (paddr == `XPS_OFS_STAGE);
  assign hit_active = (paddr == `XPS_OFS_ACTIVE);
  assign hit_pins   = (paddr == `XPS_OFS_PINS);
  assign hit_any    = hit_ctrl | hit_stage | hit_active | hit_pins;

  wire sw_apply;
  wire sw_init;
  wire sw_float;

  assign sw_apply = apb_wr & hit_ctrl & pwdata[`XPS_CTRL_APPLY];
  assign sw_init  = apb_wr & hit_ctrl & pwdata[`XPS_CTRL_INIT];
  assign sw_float = pwdata[`XPS_CTRL_FLOAT];

  // ---------------------------------------------------------------
  // Routing banks
  // ---------------------------------------------------------------
  reg [BW-1:0] stage_bank;
  reg [BW-1:0] active_bank;
  reg [BW-1:0] next_stage;
  reg [BW-1:0] next_active;
  reg [FW-1:0] init_field;
  reg          float_ctl;
  integer      k;

  always @* begin
    next_stage  = stage_bank;
    next_active = active_bank;
    float_ctl   = sw_init ? sw_float : s_float;
    init_field  = {~float_ctl, {M{1'b0}}};
    if (init_rise | sw_init) begin
      for (k = 0; k < N; k = k + 1) begin
        next_stage[k * FW +: FW]  = init_field;
        next_active[k * FW +: FW] = init_field;
      end
    end else begin
      if (apply_rise | sw_apply) begin
        next_active = stage_bank;
      end
      if (stage_rise) begin
        next_stage[s_addr * FW +: FW] = {s_en, s_sel};
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_bank  <= {BW{1'b0}};
      active_bank <= {BW{1'b0}};
    end else begin
      stage_bank  <= next_stage;
      active_bank <= next_active;
    end
  end

  // ---------------------------------------------------------------
  // Output multiplexers, one per lane
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_lane
      xps_lane #(
        .N (N),
        .M (M)
      ) u_lane (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .lane_in (data_q),
        .sel     (active_bank[g * FW +: M]),
        .en      (active_bank[g * FW + M]),
        .dout    (switch_outputs[g]),
        .oe      (switch_oe[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // APB read data and handshake
  // ---------------------------------------------------------------
  reg [31:0] rd_word;

  always @* begin
    rd_word = `XPS_RST_WORD;
    if (hit_stage) begin
      rd_word = stage_bank[31:0];
    end else if (hit_active) begin
      rd_word = active_bank[31:0];
    end else if (hit_pins) begin
      rd_word[CW-1:0] = ctl_q;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `XPS_RST_WORD;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~hit_any;
      if (psel & ~penable & ~pready & ~pwrite) begin
        prdata <= rd_word;
      end
    end
  end

endmodule

// ### tb/xps_host.sv
`timescale 1ns/1ps
module xps_host (
  input  wire        ref_clk,
  output logic       dev_sel,
  output logic       stage_strobe,
  output logic       apply_strobe,
  output logic       init_pulse,
  output logic       float_sel,
  output logic [2:0] out_addr,
  output logic [2:0] in_sel,
  output logic       in_en
);
  // ------------------------------------------------------------
  // Pin sequences, each level held 3 cycles for the synchronisers
  // ------------------------------------------------------------
  initial begin
    {dev_sel, stage_strobe, apply_strobe, init_pulse} = 4'h0;
    {float_sel, out_addr, in_sel, in_en} = 8'h00;
  end
  task hold;
    repeat (3) @(posedge ref_clk);
  endtask
  task stage(input logic [2:0] a, input logic [2:0] s, input logic e,
             input logic d);
    dev_sel  <= d;
    out_addr <= a;
    in_sel   <= s;
    in_en    <= e;
    hold();
    stage_strobe <= 1'b1;
    hold();
    stage_strobe <= 1'b0;
    hold();
  endtask
  task apply;
    apply_strobe <= 1'b1;
    hold();
    apply_strobe <= 1'b0;
    hold();
  endtask
  task init(input logic f, input logic d);
    dev_sel   <= d;
    float_sel <= f;
    hold();
    init_pulse <= 1'b1;
    hold();
    init_pulse <= 1'b0;
    hold();
  endtask
endmodule

// ### tb/xps_chk_assertions.sv
`timescale 1ns/1ps
module xps_chk #(
  parameter N = 8,
  parameter M = 3
) (
  input wire         ref_clk,
  input wire         rst_n,
  input wire         dev_sel,
  input wire         apply_strobe,
  input wire         init_pulse,
  input wire         float_sel,
  input wire         psel,
  input wire         penable,
  input wire         pwrite,
  input wire [7:0]   paddr,
  input wire [N-1:0] switch_oe,
  input wire [31:0]  prdata,
  input wire         pready,
  input wire         pslverr
);
  // Cycles since anything that may move the active bank
  logic [3:0] quiet;
  wire        kick;
  assign kick = apply_strobe || (init_pulse && dev_sel) ||
                (psel && pwrite && paddr == 8'h00);
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) quiet <= 4'h0;
    else if (kick) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_oe_quiet: assert property (quiet >= 4'ha |-> $stable(switch_oe))
    else $error("enables moved with no apply");
  a_init_drive: assert property (
    $rose(init_pulse) && dev_sel && !float_sel ##1
    (init_pulse && dev_sel && !float_sel)[*2] |-> ##[1:6] &switch_oe)
    else $error("init did not enable all");
  a_init_float: assert property (
    $rose(init_pulse) && dev_sel && float_sel ##1
    (init_pulse && dev_sel && float_sel)[*2] |-> ##[1:6] !(|switch_oe))
    else $error("init did not float all");
  a_reset_off: assert property ($rose(rst_n) |-> switch_oe == '0)
    else $error("enables set after reset");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h0c
    |=> pslverr && pready) else $error("unmapped not refused");
  a_err_mapped: assert property (psel && !penable && paddr[1:0] == 2'b00 &&
    paddr <= 8'h0c |=> !pslverr) else $error("mapped refused");
  a_err_zero: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0000_0000) else $error("refused read not zero");
  c_quiet: cover property (quiet == 4'ha);
  c_init: cover property ($rose(init_pulse) && dev_sel);
  c_err: cover property (pready && pslverr);
endmodule
bind xps_top xps_chk #(.N(N), .M(M)) u_chk (.*);

// ### tb/xps_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; \
  if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t mismatch", $time); end end
module xps_top_tb;
  logic        ref_clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  switch_inputs = 8'h55;
  wire         dev_sel, stage_strobe, apply_strobe, init_pulse;
  wire         float_sel, in_en, pready, pslverr;
  wire  [2:0]  out_addr, in_sel;
  wire  [7:0]  switch_outputs, switch_oe;
  wire  [31:0] prdata;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  xps_host u_host (.*);
  xps_top u_dut (.*);
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task t_init;
    u_host.init(1'b0, 1'b1);
    repeat (8) @(posedge ref_clk);
    `CHK(switch_oe, 8'hff)
    `CHK(switch_outputs, {8{switch_inputs[0]}})
    apb(0, 8'h04, 0); `CHK(rd, 32'h8888_8888)
    u_host.init(1'b1, 1'b1);
    repeat (8) @(posedge ref_clk);
    `CHK(switch_oe, 8'h00)
    apb(0, 8'h08, 0); `CHK(rd, 32'h0000_0000)
    u_host.init(1'b0, 1'b0);
    repeat (8) @(posedge ref_clk);
    `CHK(switch_oe, 8'h00)
  endtask
  task t_route;
    logic [31:0] w;
    w = 0;
    for (int k = 0; k < 8; k++) begin
      u_host.stage(k[2:0], 3'(7 - k), 1'b1, 1'b1);
      w[4*k+:4] = {1'b1, 3'(7 - k)};
    end
    apb(0, 8'h04, 0); `CHK(rd, w)
    `CHK(switch_oe, 8'h00)
    u_host.stage(3'd0, 3'd5, 1'b0, 1'b0);
    apb(0, 8'h04, 0); `CHK(rd, w)
    u_host.apply();
    repeat (8) @(posedge ref_clk);
    `CHK(switch_oe, 8'hff)
    `CHK(switch_outputs, 8'haa)
    switch_inputs <= 8'h0f;
    repeat (6) @(posedge ref_clk);
    `CHK(switch_outputs, 8'hf0)
    apb(0, 8'h08, 0); `CHK(rd, w)
  endtask
  task t_apb;
    apb(0, 8'h10, 0); `CHK({err, rd}, 33'h1_0000_0000)
    apb(0, 8'h0c, 0); `CHK(rd, 32'h0000_0500)
    apb(1, 8'h00, 32'h0000_0006);
    repeat (8) @(posedge ref_clk);
    `CHK(switch_oe, 8'h00)
    apb(0, 8'h04, 0); `CHK(rd, 32'h0000_0000)
    u_host.stage(3'd2, 3'd3, 1'b1, 1'b1);
    `CHK(switch_oe, 8'h00)
    apb(1, 8'h00, 32'h0000_0001);
    repeat (8) @(posedge ref_clk);
    `CHK(switch_oe, 8'h04)
    apb(0, 8'h08, 0); `CHK(rd, 32'h0000_0b00)
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    apb(0, 8'h04, 0); `CHK(rd, 32'h0000_0000)
    `CHK(switch_oe, 8'h00)
    t_init();
    t_route();
    t_apb();
    conclude();
  end
endmodule
